/* core/stack_fault_regs.svh */
// Constants for the stack fault, shadow register and table access unit
`ifndef STACK_FAULT_REGS_SVH
`define STACK_FAULT_REGS_SVH
`define DATA_W        8
`define STATUS_RST    8'h00
`define WORK_RST      8'h00
`define BANK_RST      8'h00
`define TABLE_BYTE_POINTER_W      22
`define TABLE_BYTE_POINTER_RST    22'h000000
`define TBLLAT_RST    8'h00
`define PCLO_RST      8'h00
`define RST_PULSE_CYC 4'h2
`endif

/* core/stack_fault_pkg.sv */
// Types shared by the stack fault and shadow register unit
package stack_fault_pkg;
  // Core register triple saved into the shadows
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] work;
    logic [7:0] bank;
  } core_regs_t;

  // Table access request from the sequencer
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ptr_load;
    logic [21:0] ptr_val;
    logic        lat_load;
    logic [7:0]  lat_val;
  } table_req_t;

  // Fault reset sequencer states
  typedef enum logic [2:0] {
    FR_IDLE  = 3'b001,
    FR_FLAG  = 3'b010,
    FR_RESET = 3'b100
  } fault_state_t;
endpackage

/* core/shadow_bank.sv */
// One-level shadow copy of status, working and bank-select registers
`include "stack_fault_regs.svh"
module shadow_bank (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // Save and restore controls
  input  wire logic                      save,
  input  wire logic                      restore,
  input  wire stack_fault_pkg::core_regs_t cur_regs,
  // Restore path back to the core
  output logic                           restore_vld,
  output stack_fault_pkg::core_regs_t    shadow_regs
);
  import stack_fault_pkg::*;

  core_regs_t shadow_ff;   // Single entry, never visible to software
  logic       restore_ff;  // Registered restore strobe

  ////////////////////////////////////////////////////////////////////////
  // Save overwrites whatever was held; no second level exists, so a nested
  // high priority entry clobbers a low priority save
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shadow_ff  <= {`STATUS_RST, `WORK_RST, `BANK_RST};
      restore_ff <= 1'b0;
    end else begin
      if (save) begin
        shadow_ff <= cur_regs;
      end
      restore_ff <= restore & ~save;
    end
  end

  assign shadow_regs = shadow_ff;
  assign restore_vld = restore_ff;

  a_save_capture: assert property (@(posedge sys_clk) disable iff (!rst_b)
    save |=> shadow_ff == $past(cur_regs)) else $error("shadow not captured");
endmodule

/* core/stack_fault_unit.sv */
// Stack fault detection, fast register shadows, computed jump and table access
`include "stack_fault_regs.svh"

module stack_fault_unit (
  // Clock and resets
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  input  wire logic                        por_b,
  // Configuration
  input  wire logic                        stack_fault_reset_enable,
  // Stack events and software clears
  input  wire logic                        stack_full_evt,
  input  wire logic                        stack_underflow_evt,
  input  wire logic                        sw_clr_full,
  input  wire logic                        sw_clr_underflow,
  // Shadow controls
  input  wire logic                        int_vector,
  input  wire logic                        fast_call,
  input  wire logic                        fast_return,
  input  wire logic                        fast_return_from_interrupt,
  input  wire stack_fault_pkg::core_regs_t cur_regs,
  // Computed jump and literal return
  input  wire logic                        add_working_to_file,
  input  wire logic [7:0]                  program_counter_low_byte,
  input  wire logic                        return_with_literal,
  input  wire logic [7:0]                  literal_val,
  // Table access
  input  wire stack_fault_pkg::table_req_t tbl_req,
  input  wire logic [15:0]                 prog_word_rd,
  // Fault outputs
  output logic                             stack_full_flag,
  output logic                             stack_underflow_flag,
  output logic                             fault_reset_req,
  // Shadow restore
  output logic                             restore_vld,
  output stack_fault_pkg::core_regs_t      restore_regs,
  // Computed jump result
  output logic                             pcl_wr,
  output logic [7:0]                       pcl_new,
  // Literal return result
  output logic                             lit_ret_vld,
  output logic [7:0]                       lit_ret_val,
  // Table access results
  output logic [`TABLE_BYTE_POINTER_W-1:0]             table_byte_pointer,
  output logic [7:0]                       table_data_latch,
  output logic                             prog_byte_wr,
  output logic [`TABLE_BYTE_POINTER_W-1:0]             prog_byte_addr,
  output logic [7:0]                       prog_byte_data
);
  import stack_fault_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic          full_ff;          // Sticky stack full flag
  logic          unf_ff;           // Sticky underflow flag
  fault_state_t  fstate_ff;        // Fault reset sequencer
  fault_state_t  nxt_fstate;       // Next sequencer state
  logic [3:0]    rst_cnt_ff;       // Reset pulse length counter
  logic          rst_req_ff;       // Device reset request
  logic          pcl_wr_ff;        // Program counter low write strobe
  logic [7:0]    pcl_ff;           // New program counter low value
  logic          lit_vld_ff;       // Literal return strobe
  logic [7:0]    lit_ff;           // Literal delivered to caller
  logic [21:0]   ptr_ff;           // Table byte pointer
  logic [7:0]    lat_ff;           // Table data latch
  logic          pwr_ff;           // Program byte write strobe
  logic [21:0]   paddr_ff;         // Program byte address
  logic [7:0]    pdata_ff;         // Program byte data
  logic          core_regs_ret;    // Restore strobe from shadow
  core_regs_t    shadow_q;         // Shadow contents

  ////////////////////////////////////////////////////////////////////////
  // Decode
  wire any_evt     = stack_full_evt | stack_underflow_evt;
  wire shadow_save = int_vector | fast_call;
  wire shadow_rest = fast_return_from_interrupt | fast_return;
  wire [7:0] pcl_sum = program_counter_low_byte + cur_regs.work;
  // Low pointer bit picks which byte of the 16-bit word is read
  wire [7:0] rd_byte = ptr_ff[0] ? prog_word_rd[15:8] : prog_word_rd[7:0];
  wire nxt_full = stack_full_evt | (full_ff & ~sw_clr_full);
  wire nxt_unf  = stack_underflow_evt | (unf_ff & ~sw_clr_underflow);

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags live on power-on reset only, so a fault reset leaves them
  // readable as the reset cause; an event in a clear cycle wins
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      full_ff <= 1'b0;
      unf_ff  <= 1'b0;
    end else begin
      full_ff <= nxt_full;
      unf_ff  <= nxt_unf;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fault sequencer: flag is set first, reset follows one cycle later
  always_comb begin
    nxt_fstate = fstate_ff;
    unique case (fstate_ff)
      FR_IDLE:  if (any_evt && stack_fault_reset_enable) nxt_fstate = FR_FLAG;
      FR_FLAG:  nxt_fstate = FR_RESET;
      FR_RESET: if (rst_cnt_ff == 4'h1) nxt_fstate = FR_IDLE;
      default:  nxt_fstate = FR_IDLE;
    endcase
  end

  // Sequencer state and reset pulse; held on power-on reset so the device
  // reset it drives cannot cut its own pulse short
  always_ff @(posedge sys_clk or negedge por_b) begin
    if (!por_b) begin
      fstate_ff  <= FR_IDLE;
      rst_cnt_ff <= 4'h0;
      rst_req_ff <= 1'b0;
    end else begin
      fstate_ff  <= nxt_fstate;
      rst_cnt_ff <= (fstate_ff == FR_FLAG) ? `RST_PULSE_CYC :
                    (rst_cnt_ff != 4'h0) ? rst_cnt_ff - 4'h1 : 4'h0;
      rst_req_ff <= (nxt_fstate == FR_RESET);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shadow registers
  shadow_bank u_shadow (
    .sys_clk     (sys_clk),
    .rst_b       (rst_b),
    .save        (shadow_save),
    .restore     (shadow_rest),
    .cur_regs    (cur_regs),
    .restore_vld (core_regs_ret),
    .shadow_regs (shadow_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Computed jump and literal return
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcl_wr_ff  <= 1'b0;
      pcl_ff     <= `PCLO_RST;
      lit_vld_ff <= 1'b0;
      lit_ff     <= 8'h00;
    end else begin
      pcl_wr_ff  <= add_working_to_file;
      if (add_working_to_file) pcl_ff <= pcl_sum;
      lit_vld_ff <= return_with_literal;
      if (return_with_literal) lit_ff <= literal_val;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Table pointer and latch: one byte per operation
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_ff   <= `TABLE_BYTE_POINTER_RST;
      lat_ff   <= `TBLLAT_RST;
      pwr_ff   <= 1'b0;
      paddr_ff <= `TABLE_BYTE_POINTER_RST;
      pdata_ff <= 8'h00;
    end else begin
      if (tbl_req.ptr_load) ptr_ff <= tbl_req.ptr_val;
      // Read takes priority over a latch load in the same cycle
      if (tbl_req.rd) lat_ff <= rd_byte;
      else if (tbl_req.lat_load) lat_ff <= tbl_req.lat_val;
      pwr_ff <= tbl_req.wr & ~tbl_req.rd;
      if (tbl_req.wr) begin
        paddr_ff <= ptr_ff;
        pdata_ff <= lat_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  assign stack_full_flag      = full_ff;
  assign stack_underflow_flag = unf_ff;
  assign fault_reset_req      = rst_req_ff;
  assign restore_vld          = core_regs_ret;
  assign restore_regs         = shadow_q;
  assign pcl_wr               = pcl_wr_ff;
  assign pcl_new              = pcl_ff;
  assign lit_ret_vld          = lit_vld_ff;
  assign lit_ret_val          = lit_ff;
  assign table_byte_pointer   = ptr_ff;
  assign table_data_latch     = lat_ff;
  assign prog_byte_wr         = pwr_ff;
  assign prog_byte_addr       = paddr_ff;
  assign prog_byte_data       = pdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Assertions
  a_flag_before_rst: assert property (@(posedge sys_clk) disable iff (!por_b)
    (fstate_ff == FR_IDLE && any_evt && stack_fault_reset_enable) |=> (full_ff | unf_ff) ##1 rst_req_ff)
    else $error("fault reset not after flag");
  a_no_rst_disabled: assert property (@(posedge sys_clk) disable iff (!por_b)
    (fstate_ff == FR_IDLE && !stack_fault_reset_enable && any_evt) |=> ##1 !rst_req_ff)
    else $error("reset while disabled");
  a_flag_sticky: assert property (@(posedge sys_clk) disable iff (!por_b)
    (full_ff && !sw_clr_full) |=> full_ff) else $error("full flag lost");
  a_evt_sets_unf: assert property (@(posedge sys_clk) disable iff (!por_b)
    stack_underflow_evt |=> unf_ff) else $error("underflow flag not set");
  a_restore_value: assert property (@(posedge sys_clk) disable iff (!rst_b)
    shadow_save ##1 (fast_return_from_interrupt && !shadow_save) |=>
    restore_vld && restore_regs == $past(cur_regs, 2)) else $error("restore mismatch");
  a_vector_saves: assert property (@(posedge sys_clk) disable iff (!rst_b)
    int_vector |=> restore_regs == $past(cur_regs))
    else $error("vector save lost");
  a_pcl_advance: assert property (@(posedge sys_clk) disable iff (!rst_b)
    add_working_to_file |=> pcl_wr && pcl_new == $past(program_counter_low_byte) + $past(cur_regs.work))
    else $error("pcl advance wrong");
  a_literal_ret: assert property (@(posedge sys_clk) disable iff (!rst_b)
    return_with_literal |=> lit_ret_vld && lit_ret_val == $past(literal_val)) else $error("literal lost");
  a_table_byte: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (tbl_req.rd && ptr_ff[0]) |=> table_data_latch == $past(prog_word_rd[15:8])) else $error("high byte wrong");
endmodule

/* tb/prog_mem_model.sv */
// Program memory model that answers table reads for the unit
module prog_mem_model (
  // Byte address from the table pointer
  input  wire logic [21:0] byte_addr,
  // Program word at the word address of that byte
  output logic      [15:0] word_rd
);
  // The halves differ so that a swapped byte lane shows up
  assign word_rd = {byte_addr[8:1] ^ 8'ha5, byte_addr[8:1]};
endmodule

/* tb/stack_fault_and_shadow_regs_tb_top.sv */
// Self-checking bench for the stack fault and shadow register unit
module stack_fault_and_shadow_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import stack_fault_pkg::*;
  ////////////////////////////////////////////////////////////
  // Stimulus into the unit
  logic        sys_clk, rst_b, por_b, stack_fault_reset_enable;
  logic        stack_full_evt, stack_underflow_evt, sw_clr_full, sw_clr_underflow;
  logic        int_vector, fast_call, fast_return, fast_return_from_interrupt;
  logic        add_working_to_file, return_with_literal;
  logic [7:0]  program_counter_low_byte, literal_val;
  core_regs_t  cur_regs;
  table_req_t  tbl_req;
  logic [15:0] prog_word_rd;
  // Results from the unit
  logic        stack_full_flag, stack_underflow_flag, fault_reset_req;
  logic        restore_vld, pcl_wr, lit_ret_vld, prog_byte_wr;
  core_regs_t  restore_regs;
  logic [7:0]  pcl_new, lit_ret_val, table_data_latch, prog_byte_data;
  logic [21:0] table_byte_pointer, prog_byte_addr;
  // Counters for the final report
  int          num_errors, samples_checked;
  ////////////////////////////////////////////////////////////
  stack_fault_unit stack_fault_unit_inst (
    .sys_clk, .rst_b, .por_b, .stack_fault_reset_enable, .stack_full_evt, .stack_underflow_evt,
    .sw_clr_full, .sw_clr_underflow, .int_vector, .fast_call, .fast_return, .fast_return_from_interrupt,
    .cur_regs, .add_working_to_file, .program_counter_low_byte, .return_with_literal, .literal_val,
    .tbl_req, .prog_word_rd, .stack_full_flag, .stack_underflow_flag, .fault_reset_req, .restore_vld,
    .restore_regs, .pcl_wr, .pcl_new, .lit_ret_vld, .lit_ret_val, .table_byte_pointer,
    .table_data_latch, .prog_byte_wr, .prog_byte_addr, .prog_byte_data
  );
  prog_mem_model prog_mem_model_inst (.byte_addr(table_byte_pointer), .word_rd(prog_word_rd));
  // 200 MHz core clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////
  // Inputs move 1 ns after the edge so sampling never races
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // Case equality keeps an unknown from passing as a match
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d, checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Enabled fault: flag first, then a two-cycle reset request
  task automatic fault_enabled();
    stack_fault_reset_enable = 1'b1;
    stack_full_evt = 1'b1;
    tick();
    stack_full_evt = 1'b0;
    chk({stack_full_flag, fault_reset_req}, 2'b10);
    tick();
    chk(fault_reset_req, 1'b1);
    tick();
    chk(fault_reset_req, 1'b1);
    tick();
    chk(fault_reset_req, 1'b0);
  endtask
  // Flag rides through a general reset, other clear leaves it
  task automatic flags_hold();
    rst_b = 1'b0;
    tick();
    rst_b = 1'b1;
    sw_clr_underflow = 1'b1;
    tick();
    sw_clr_underflow = 1'b0;
    tick();
    chk(stack_full_flag, 1'b1);
    sw_clr_full = 1'b1;
    tick();
    sw_clr_full = 1'b0;
    tick();
    chk(stack_full_flag, 1'b0);
  endtask
  // Disabled fault: flag only, then power-on reset clears it
  task automatic fault_disabled();
    stack_fault_reset_enable = 1'b0;
    stack_underflow_evt = 1'b1;
    tick();
    stack_underflow_evt = 1'b0;
    repeat (4) begin
      tick();
      chk(fault_reset_req, 1'b0);
    end
    chk(stack_underflow_flag, 1'b1);
    por_b = 1'b0;
    tick();
    por_b = 1'b1;
    tick();
    chk(stack_underflow_flag, 1'b0);
  endtask
  // Two nested entries, then a fast interrupt return
  task automatic shadow_int();
    cur_regs = 24'h112233;
    int_vector = 1'b1;
    tick();
    cur_regs = 24'h445566;
    tick();
    int_vector = 1'b0;
    cur_regs = 24'h000000;
    fast_return_from_interrupt = 1'b1;
    tick();
    fast_return_from_interrupt = 1'b0;
    chk({restore_vld, restore_regs}, 25'h1445566);
    tick();
    chk(restore_vld, 1'b0);
  endtask
  // Fast call saves, fast return restores, pulse lasts one cycle
  task automatic shadow_call();
    cur_regs = 24'ha1b2c3;
    fast_call = 1'b1;
    tick();
    fast_call = 1'b0;
    cur_regs = 24'h000000;
    fast_return = 1'b1;
    tick();
    fast_return = 1'b0;
    chk({restore_vld, restore_regs}, 25'h1a1b2c3);
    tick();
    chk(restore_vld, 1'b0);
  endtask
  // Jump wraps modulo 256; literal return in the same cycle
  task automatic jump_and_literal();
    cur_regs.work = 8'h12;
    program_counter_low_byte = 8'hf0;
    literal_val = 8'h5a;
    add_working_to_file = 1'b1;
    return_with_literal = 1'b1;
    tick();
    add_working_to_file = 1'b0;
    return_with_literal = 1'b0;
    chk({pcl_wr, pcl_new}, 9'h102);
    chk({lit_ret_vld, lit_ret_val}, 9'h15a);
  endtask
  // Load the pointer, then read one byte into the latch
  task automatic table_read(input logic [21:0] ptr, input logic [7:0] exp);
    tbl_req.ptr_val = ptr;
    tbl_req.ptr_load = 1'b1;
    tick();
    tbl_req.ptr_load = 1'b0;
    tbl_req.rd = 1'b1;
    tick();
    tbl_req.rd = 1'b0;
    tick();
    chk({table_byte_pointer, table_data_latch}, {ptr, exp});
  endtask
  // Both bytes of one word, then a single byte write
  task automatic table_ops();
    table_read(22'h000102, 8'h81);
    table_read(22'h000103, 8'h24);
    tbl_req.wr = 1'b1;
    tick();
    tbl_req.wr = 1'b0;
    chk({prog_byte_wr, prog_byte_addr, prog_byte_data}, 31'h40010324);
    // Direct latch load, with the write strobe dropped again
    tbl_req.lat_val = 8'h3c;
    tbl_req.lat_load = 1'b1;
    tick();
    tbl_req.lat_load = 1'b0;
    chk({prog_byte_wr, table_data_latch}, 9'h03c);
  endtask
  ////////////////////////////////////////////////////////////
  // Main sequence: both resets held two cycles
  initial begin
    {rst_b, por_b, stack_fault_reset_enable, stack_full_evt, stack_underflow_evt} = '0;
    {sw_clr_full, sw_clr_underflow, int_vector, fast_call, fast_return} = '0;
    {fast_return_from_interrupt, add_working_to_file, return_with_literal} = '0;
    {program_counter_low_byte, literal_val, cur_regs, tbl_req} = '0;
    num_errors = 0;
    samples_checked = 0;
    repeat (2) tick();
    rst_b = 1'b1;
    por_b = 1'b1;
    tick();
    fault_enabled();
    flags_hold();
    fault_disabled();
    shadow_int();
    shadow_call();
    jump_and_literal();
    table_ops();
    end_of_test();
  end
  // Guard against a hang
  initial begin
    #100000;
    num_errors++;
    end_of_test();
  end
endmodule
